// file: hw/fcm_map.svh
`ifndef FCM_MAP_SVH
`define FCM_MAP_SVH
// Behaviour
// R1 - monitor one tx and one rx channel
// R2 - selected channel byte shown in monitor register
// R3 - channel select is zero based
// R4 - tx per-channel idle code replaces data
// R5 - rx per-channel idle code replaces data
// R6 - looped channels take receive line data
// R7 - system keeps tx and rx timing aligned
// R8 - CRC-4 follows Sa changes, keeps errors
// R9 - recalculation needs CRC-4 insertion enabled
// R10 - tx sync runs in multiframe mode
// R11 - T1 loop codes 1-8 or 16 bits; code sends 5, 6, 7 or 16 bits and detects 1-7 or 16
// R12 - software fills code registers per length
// R13 - loop code sent while send bit set
// R14 - F-bit overwrites pattern unless suppressed
// R15 - length 00 with 80h gives 10000
// R16 - three detectors with own codes, lengths
// R17 - 16-bit uses both, short uses first
// R18 - detection tolerates errors and F-bits
// R19 - low code write restarts integration
// R20 - detect status after 48 ms integration
// R21 - realtime, latched set/clear and mask bits
// R22 - software polls detect status repeatedly
// R23 - latched bits clear on written one
// R24 - monitor byte refreshed once per frame
// R25 - enable bits map channels ascending
// ***********************************************
// register offsets
// ***********************************************
`define FCM_A_RX_MON_SEL   9'h012
`define FCM_A_RX_MON_DATA  9'h060
`define FCM_A_RX_LEN_CTL   9'h082
`define FCM_A_RX_LATCHED   9'h092
`define FCM_A_RX_SPARE_HI  9'h09c
`define FCM_A_RX_SPARE_LO  9'h09d
`define FCM_A_RX_MASK      9'h0a2
`define FCM_A_RX_UP_HI     9'h0ac
`define FCM_A_RX_UP_LO     9'h0ad
`define FCM_A_RX_DN_HI     9'h0ae
`define FCM_A_RX_DN_LO     9'h0af
`define FCM_A_RX_REALTIME  9'h0b2
`define FCM_A_RX_IDLE_BASE 9'h0c0
`define FCM_A_RX_IDLE_EN   9'h0e0
`define FCM_A_RX_SPARE_CTL 9'h0e4
`define FCM_A_TX_CTL1      9'h181
`define FCM_A_TX_CTL3      9'h183
`define FCM_A_TX_CTL4      9'h186
`define FCM_A_TX_MON_SEL   9'h189
`define FCM_A_TX_CODE1     9'h1ac
`define FCM_A_TX_CODE2     9'h1ad
`define FCM_A_TX_MON_DATA  9'h1bb
`define FCM_A_TX_IDLE_BASE 9'h1c0
`define FCM_A_TX_IDLE_EN   9'h1e0
`define FCM_A_LOOPBACK_EN  9'h1e4
// ***********************************************
// fields, reset values, timing
// ***********************************************
`define FCM_B_CRC4_INS     0
`define FCM_B_T1_MODE      1
`define FCM_B_F_INS_OFF    2
`define FCM_B_CTL3_MODE    0
`define FCM_B_CBIT         7
`define FCM_B_FBIT         0
`define FCM_F_TX_LEN       1:0
`define FCM_F_UP_LEN       2:0
`define FCM_F_DN_LEN       5:3
`define FCM_F_SP_LEN       2:0
`define FCM_F_CHAN         4:0
`define FCM_F_EVENTS       5:0
`define FCM_RST_BYTE       8'h00
`define FCM_BYTE_W         8
`define FCM_CRC4_POLY      4'h3
`define FCM_RX_WIDE_CODE   3'h7
`define FCM_LEN_WIDE       5'h10
`define FCM_TX_LEN0        5'h05
`define FCM_TX_LEN1        5'h06
`define FCM_TX_LEN2        5'h07
`define FCM_SLIP_ERRS      4'h2
`define FCM_ERR_SHIFT      5
`define FCM_CLK_KHZ        10000
`define FCM_INTEG_MS       48
`endif

// file: hw/fcm_pkg.sv
package fcm_pkg;
   // one timeslot of a backplane or line stream
   typedef struct packed {
      logic       valid;
      logic       fslot;
      logic       mfs;
      logic [4:0] chan;
      logic [7:0] data;
   } fcm_slot_t;
endpackage

// file: hw/fcm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcm_map.svh"
module fcm_top #(
   parameter int INTEG_CYCLES = `FCM_INTEG_MS * `FCM_CLK_KHZ,
   parameter int NCHAN        = 32
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [8:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  logic [7:0]        reg_rdata_q,
   input  wire fcm_pkg::fcm_slot_t tx_in,
   input  wire fcm_pkg::fcm_slot_t rx_in,
   output var  fcm_pkg::fcm_slot_t tx_out_q,
   output var  fcm_pkg::fcm_slot_t rx_out_q,
   output var  logic              loop_event_q
);
   import fcm_pkg::*;
   localparam int CW = $clog2(INTEG_CYCLES + 1);
   localparam int BW = CW + 3;

   logic [7:0]       tx_ctl1_q, tx_ctl3_q, tx_ctl4_q, tx_sel_q, rx_sel_q;
   logic [7:0]       code1_q, code2_q, len_ctl_q, spare_ctl_q, mask_q;
   logic [7:0]       tx_mon_q, rx_mon_q, rd_d;
   logic [7:0]       tx_idle_q [NCHAN];
   logic [7:0]       rx_idle_q [NCHAN];
   logic [7:0]       rx_hold_q [NCHAN];
   logic [NCHAN-1:0] tx_idle_en_q, rx_idle_en_q, loop_en_q;
   logic [15:0]      def_q [3];
   logic [2:0]       det_len_code [3];
   logic [CW-1:0]    tmr_q [3];
   logic [BW-1:0]    bits_q [3];
   logic [BW-1:0]    err_q [3];
   logic [3:0]       ph_q [3];
   logic [2:0]       rt_q, det_end, det_ok, det_set, det_clr, det_restart;
   logic [5:0]       latched_q;
   logic [3:0]       gen_idx_q, frame_q, cur_fr;
   logic [3:0]       acc_in_q, acc_out_q, prev_in_q, prev_out_q, use_in, use_out;
   logic [7:0]       in_b, out_b, pat_b;
   logic             t1, loop_send, recalc, f_ins_off, tx_pay, rx_pay, ts0, c_slot, smf_start;
   logic [4:0]       tx_len;
   fcm_slot_t        tx_d, rx_d;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic blk_hit(input logic [8:0] a, input logic [8:0] base);
      return a[8:5] == base[8:5];
   endfunction

   function automatic logic quad_hit(input logic [8:0] a, input logic [8:0] base);
      return a[8:2] == base[8:2];
   endfunction

   function automatic logic [3:0] adv(input logic [3:0] i, input logic [4:0] len, input int n);
      logic [3:0] r;
      r = i;
      for (int k = 0; k < n; k++) begin
         r = (({1'b0, r} + 5'h1) >= len) ? 4'h0 : r + 4'h1;
      end
      return r;
   endfunction

   // pattern is walked msb first, repeating every len bits
   function automatic logic [7:0] gen_byte(input logic [15:0] p, input logic [3:0] i, input logic [4:0] len);
      logic [3:0] r;
      logic [7:0] b;
      r = i;
      b = '0;
      for (int k = `FCM_BYTE_W - 1; k >= 0; k--) begin
         b[k] = p[~r];
         r = adv(r, len, 1);
      end
      return b;
   endfunction

   function automatic logic [3:0] det_errs(input logic [15:0] p, input logic [3:0] i, input logic [4:0] len,
                                           input logic [7:0] b);
      logic [3:0] r;
      logic [3:0] e;
      r = i;
      e = '0;
      for (int k = `FCM_BYTE_W - 1; k >= 0; k--) begin
         e = e + {3'h0, b[k] != p[~r]};
         r = adv(r, len, 1);
      end
      return e;
   endfunction

   function automatic logic [3:0] crc4_byte(input logic [3:0] c, input logic [7:0] b);
      logic [3:0] r;
      logic       fb;
      r = c;
      for (int k = `FCM_BYTE_W - 1; k >= 0; k--) begin
         fb = r[3] ^ b[k];
         r = {r[2:0], 1'b0} ^ (fb ? `FCM_CRC4_POLY : 4'h0);
      end
      return r;
   endfunction

   function automatic logic [4:0] rx_len(input logic [2:0] c);
      return (c == `FCM_RX_WIDE_CODE) ? `FCM_LEN_WIDE : {2'h0, c} + 5'h1;
   endfunction

   // ***********************************************
   // control registers
   // ***********************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ctl1_q   <= `FCM_RST_BYTE;
         tx_ctl3_q   <= `FCM_RST_BYTE;
         tx_ctl4_q   <= `FCM_RST_BYTE;
         tx_sel_q    <= `FCM_RST_BYTE;
         rx_sel_q    <= `FCM_RST_BYTE;
         code1_q     <= `FCM_RST_BYTE;
         code2_q     <= `FCM_RST_BYTE;
         len_ctl_q   <= `FCM_RST_BYTE;
         spare_ctl_q <= `FCM_RST_BYTE;
         mask_q      <= `FCM_RST_BYTE;
      end else if (reg_wr) begin
         if (reg_addr == `FCM_A_TX_CTL1) tx_ctl1_q <= reg_wdata;
         else if (reg_addr == `FCM_A_TX_CTL3) tx_ctl3_q <= reg_wdata;
         else if (reg_addr == `FCM_A_TX_CTL4) tx_ctl4_q <= reg_wdata;
         else if (reg_addr == `FCM_A_TX_MON_SEL) tx_sel_q <= reg_wdata;
         else if (reg_addr == `FCM_A_RX_MON_SEL) rx_sel_q <= reg_wdata;
         else if (reg_addr == `FCM_A_TX_CODE1) code1_q <= reg_wdata;
         else if (reg_addr == `FCM_A_TX_CODE2) code2_q <= reg_wdata;
         else if (reg_addr == `FCM_A_RX_LEN_CTL) len_ctl_q <= reg_wdata;
         else if (reg_addr == `FCM_A_RX_SPARE_CTL) spare_ctl_q <= reg_wdata;
         else if (reg_addr == `FCM_A_RX_MASK) mask_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NCHAN; i++) begin
            tx_idle_q[i] <= `FCM_RST_BYTE;
            rx_idle_q[i] <= `FCM_RST_BYTE;
         end
      end else if (reg_wr) begin
         if (blk_hit(reg_addr, `FCM_A_TX_IDLE_BASE)) tx_idle_q[reg_addr[`FCM_F_CHAN]] <= reg_wdata; // [R4]
         else if (blk_hit(reg_addr, `FCM_A_RX_IDLE_BASE)) rx_idle_q[reg_addr[`FCM_F_CHAN]] <= reg_wdata; // [R5]
      end
   end

   // byte k bit j enables channel 8k+j
   for (genvar k = 0; k < NCHAN / `FCM_BYTE_W; k++) begin : g_en
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            tx_idle_en_q[k*`FCM_BYTE_W +: `FCM_BYTE_W] <= `FCM_RST_BYTE;
            rx_idle_en_q[k*`FCM_BYTE_W +: `FCM_BYTE_W] <= `FCM_RST_BYTE;
            loop_en_q[k*`FCM_BYTE_W +: `FCM_BYTE_W]    <= `FCM_RST_BYTE;
         end else if (reg_wr && reg_addr[1:0] == 2'(k)) begin
            if (quad_hit(reg_addr, `FCM_A_TX_IDLE_EN)) tx_idle_en_q[k*`FCM_BYTE_W +: `FCM_BYTE_W] <= reg_wdata; // [R25]
            else if (quad_hit(reg_addr, `FCM_A_RX_IDLE_EN)) rx_idle_en_q[k*`FCM_BYTE_W +: `FCM_BYTE_W] <= reg_wdata;
            else if (quad_hit(reg_addr, `FCM_A_LOOPBACK_EN)) loop_en_q[k*`FCM_BYTE_W +: `FCM_BYTE_W] <= reg_wdata;
         end
      end
   end

   // ***********************************************
   // transmit path
   // ***********************************************
   assign t1        = tx_ctl1_q[`FCM_B_T1_MODE];
   assign f_ins_off = tx_ctl1_q[`FCM_B_F_INS_OFF];
   // the same control bit means loop-code send in T1 and CRC-4 recalculation in E1
   assign loop_send = t1 & tx_ctl3_q[`FCM_B_CTL3_MODE]; // [R11] [R13]
   assign recalc    = ~t1 & tx_ctl3_q[`FCM_B_CTL3_MODE] & tx_ctl1_q[`FCM_B_CRC4_INS]; // [R9]
   assign tx_pay    = tx_in.valid & ~tx_in.fslot;
   assign ts0       = tx_pay & (tx_in.chan == '0);
   assign cur_fr    = (ts0 && tx_in.mfs) ? 4'h0 : (ts0 ? frame_q + 4'h1 : frame_q); // [R10]
   assign c_slot    = ts0 & ~cur_fr[0];
   assign smf_start = ts0 & (cur_fr[2:0] == 3'h0);
   assign use_in    = smf_start ? acc_in_q : prev_in_q;
   assign use_out   = smf_start ? acc_out_q : prev_out_q;
   assign pat_b     = gen_byte({code1_q, code2_q}, gen_idx_q, tx_len);

   always_comb begin
      case (tx_ctl4_q[`FCM_F_TX_LEN])
         2'h0:    tx_len = `FCM_TX_LEN0; // [R15]
         2'h1:    tx_len = `FCM_TX_LEN1;
         2'h2:    tx_len = `FCM_TX_LEN2;
         default: tx_len = `FCM_LEN_WIDE; // [R12]
      endcase
   end

   always_comb begin
      tx_d  = tx_in;
      in_b  = tx_in.data;
      out_b = '0;
      if (tx_pay) begin
         if (loop_en_q[tx_in.chan]) tx_d.data = rx_hold_q[tx_in.chan]; // [R6]
         if (tx_idle_en_q[tx_in.chan]) tx_d.data = tx_idle_q[tx_in.chan]; // [R4]
         if (loop_send) tx_d.data = pat_b; // [R13]
         // outgoing C bit = incoming C bit corrected by the data change, so errors survive
         if (recalc && c_slot) begin
            tx_d.data[`FCM_B_CBIT] = tx_in.data[`FCM_B_CBIT] ^ use_in[~cur_fr[2:1]] ^ use_out[~cur_fr[2:1]]; // [R8]
         end
         if (c_slot) in_b[`FCM_B_CBIT] = 1'b0;
         out_b = tx_d.data;
         if (c_slot) out_b[`FCM_B_CBIT] = 1'b0;
      end else if (tx_in.valid && loop_send && f_ins_off) begin
         tx_d.data[`FCM_B_FBIT] = pat_b[`FCM_BYTE_W-1]; // [R14]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) tx_out_q <= '0;
      else tx_out_q <= tx_d;
   end

   // pattern keeps running under the F position, so its phase never skips
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) gen_idx_q <= '0;
      else if (!loop_send) gen_idx_q <= '0;
      else if (tx_pay) gen_idx_q <= adv(gen_idx_q, tx_len, `FCM_BYTE_W); // [R13]
      else if (tx_in.valid) gen_idx_q <= adv(gen_idx_q, tx_len, 1); // [R14]
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q    <= '0;
         acc_in_q   <= '0;
         acc_out_q  <= '0;
         prev_in_q  <= '0;
         prev_out_q <= '0;
      end else if (tx_pay) begin
         frame_q <= cur_fr;
         if (smf_start) begin
            prev_in_q  <= acc_in_q;
            prev_out_q <= acc_out_q;
            acc_in_q   <= crc4_byte(4'h0, in_b); // [R8]
            acc_out_q  <= crc4_byte(4'h0, out_b);
         end else begin
            acc_in_q  <= crc4_byte(acc_in_q, in_b);
            acc_out_q <= crc4_byte(acc_out_q, out_b);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) tx_mon_q <= `FCM_RST_BYTE;
      else if (tx_out_q.valid && !tx_out_q.fslot && tx_out_q.chan == tx_sel_q[`FCM_F_CHAN]) tx_mon_q <= tx_out_q.data; // [R2] [R24]
   end

   // ***********************************************
   // receive path
   // ***********************************************
   assign rx_pay = rx_in.valid & ~rx_in.fslot;

   always_comb begin
      rx_d = rx_in;
      if (rx_pay && rx_idle_en_q[rx_in.chan]) rx_d.data = rx_idle_q[rx_in.chan]; // [R5]
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) rx_out_q <= '0;
      else rx_out_q <= rx_d;
   end

   // loopback relies on the system keeping tx and rx frames aligned
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NCHAN; i++) rx_hold_q[i] <= `FCM_RST_BYTE;
      end else if (rx_pay) begin
         rx_hold_q[rx_in.chan] <= rx_in.data; // [R6] [R7]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) rx_mon_q <= `FCM_RST_BYTE;
      else if (rx_pay && rx_in.chan == rx_sel_q[`FCM_F_CHAN]) rx_mon_q <= rx_in.data; // [R1] [R3] [R24]
   end

   // ***********************************************
   // loop code detectors
   // ***********************************************
   assign det_len_code[0] = len_ctl_q[`FCM_F_UP_LEN];
   assign det_len_code[1] = len_ctl_q[`FCM_F_DN_LEN];
   assign det_len_code[2] = spare_ctl_q[`FCM_F_SP_LEN];

   // F slots are skipped, so framed, unframed, inserted and overwritten F all pass
   for (genvar d = 0; d < 3; d++) begin : g_det
      localparam logic [8:0] HI_A = (d == 0) ? `FCM_A_RX_UP_HI : ((d == 1) ? `FCM_A_RX_DN_HI : `FCM_A_RX_SPARE_HI);
      localparam logic [8:0] LO_A = (d == 0) ? `FCM_A_RX_UP_LO : ((d == 1) ? `FCM_A_RX_DN_LO : `FCM_A_RX_SPARE_LO);
      logic [3:0] e;
      assign e              = det_errs(def_q[d], ph_q[d], rx_len(det_len_code[d]), rx_in.data);
      assign det_restart[d] = reg_wr && reg_addr == LO_A;
      assign det_end[d]     = tmr_q[d] == CW'(INTEG_CYCLES - 1);
      // error ceiling of one in 32 bits leaves room for a 1e-2 error rate
      assign det_ok[d]      = bits_q[d] != '0 && err_q[d] <= (bits_q[d] >> `FCM_ERR_SHIFT); // [R18]
      // a restart in the end cycle drops the period, so no event may latch
      assign det_set[d]     = det_end[d] & ~det_restart[d] & det_ok[d] & ~rt_q[d];
      assign det_clr[d]     = det_end[d] & ~det_restart[d] & ~det_ok[d] & rt_q[d];

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) def_q[d] <= '0;
         else if (reg_wr && reg_addr == HI_A) def_q[d][15:8] <= reg_wdata; // [R16] [R17]
         else if (det_restart[d]) def_q[d][7:0] <= reg_wdata;
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            tmr_q[d]  <= '0;
            bits_q[d] <= '0;
            err_q[d]  <= '0;
            ph_q[d]   <= '0;
            rt_q[d]   <= 1'b0;
         end else if (det_restart[d]) begin
            tmr_q[d]  <= '0; // [R19]
            bits_q[d] <= '0;
            err_q[d]  <= '0;
            ph_q[d]   <= '0;
         end else if (det_end[d]) begin
            tmr_q[d]  <= '0;
            bits_q[d] <= '0;
            err_q[d]  <= '0;
            rt_q[d]   <= det_ok[d]; // [R20] [R21]
         end else begin
            tmr_q[d] <= tmr_q[d] + CW'(1);
            if (rx_pay && t1) begin
               bits_q[d] <= bits_q[d] + BW'(`FCM_BYTE_W);
               err_q[d]  <= err_q[d] + BW'(e);
               // slip one bit when this phase looks wrong, hunting for alignment
               ph_q[d] <= adv(ph_q[d], rx_len(det_len_code[d]),
                              (e >= `FCM_SLIP_ERRS) ? `FCM_BYTE_W + 1 : `FCM_BYTE_W); // [R18]
            end
         end
      end
   end

   // set wins over a simultaneous write of one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) latched_q <= '0;
      else latched_q <= (latched_q & ~((reg_wr && reg_addr == `FCM_A_RX_LATCHED) ? reg_wdata[`FCM_F_EVENTS] : 6'h0))
                        | {det_clr, det_set}; // [R21] [R23]
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) loop_event_q <= 1'b0;
      else loop_event_q <= |(latched_q & mask_q[`FCM_F_EVENTS]); // [R21]
   end

   // ***********************************************
   // register read
   // ***********************************************
   always_comb begin
      rd_d = '0;
      if (reg_addr == `FCM_A_TX_CTL1) rd_d = tx_ctl1_q;
      else if (reg_addr == `FCM_A_TX_CTL3) rd_d = tx_ctl3_q;
      else if (reg_addr == `FCM_A_TX_CTL4) rd_d = tx_ctl4_q;
      else if (reg_addr == `FCM_A_TX_MON_SEL) rd_d = tx_sel_q;
      else if (reg_addr == `FCM_A_RX_MON_SEL) rd_d = rx_sel_q;
      else if (reg_addr == `FCM_A_TX_MON_DATA) rd_d = tx_mon_q; // [R2]
      else if (reg_addr == `FCM_A_RX_MON_DATA) rd_d = rx_mon_q;
      else if (reg_addr == `FCM_A_TX_CODE1) rd_d = code1_q;
      else if (reg_addr == `FCM_A_TX_CODE2) rd_d = code2_q;
      else if (reg_addr == `FCM_A_RX_LEN_CTL) rd_d = len_ctl_q;
      else if (reg_addr == `FCM_A_RX_SPARE_CTL) rd_d = spare_ctl_q;
      else if (reg_addr == `FCM_A_RX_MASK) rd_d = mask_q;
      else if (reg_addr == `FCM_A_RX_UP_HI) rd_d = def_q[0][15:8];
      else if (reg_addr == `FCM_A_RX_UP_LO) rd_d = def_q[0][7:0];
      else if (reg_addr == `FCM_A_RX_DN_HI) rd_d = def_q[1][15:8];
      else if (reg_addr == `FCM_A_RX_DN_LO) rd_d = def_q[1][7:0];
      else if (reg_addr == `FCM_A_RX_SPARE_HI) rd_d = def_q[2][15:8];
      else if (reg_addr == `FCM_A_RX_SPARE_LO) rd_d = def_q[2][7:0];
      else if (reg_addr == `FCM_A_RX_REALTIME) rd_d = {5'h0, rt_q}; // [R21]
      else if (reg_addr == `FCM_A_RX_LATCHED) rd_d = {2'h0, latched_q};
      else if (blk_hit(reg_addr, `FCM_A_TX_IDLE_BASE)) rd_d = tx_idle_q[reg_addr[`FCM_F_CHAN]];
      else if (blk_hit(reg_addr, `FCM_A_RX_IDLE_BASE)) rd_d = rx_idle_q[reg_addr[`FCM_F_CHAN]];
      else if (quad_hit(reg_addr, `FCM_A_TX_IDLE_EN)) rd_d = tx_idle_en_q[reg_addr[1:0]*`FCM_BYTE_W +: `FCM_BYTE_W];
      else if (quad_hit(reg_addr, `FCM_A_RX_IDLE_EN)) rd_d = rx_idle_en_q[reg_addr[1:0]*`FCM_BYTE_W +: `FCM_BYTE_W];
      else if (quad_hit(reg_addr, `FCM_A_LOOPBACK_EN)) rd_d = loop_en_q[reg_addr[1:0]*`FCM_BYTE_W +: `FCM_BYTE_W];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) reg_rdata_q <= '0;
      else reg_rdata_q <= reg_rd ? rd_d : '0;
   end

   // ***********************************************
   // checks
   // ***********************************************
   sequence lpbk_slot_s;
      tx_pay && loop_en_q[tx_in.chan] && !tx_idle_en_q[tx_in.chan] && !loop_send && !recalc;
   endsequence
   sequence rt_read_s;
      reg_rd && reg_addr == `FCM_A_RX_REALTIME;
   endsequence

   rt_readback_a: assert property (rt_read_s |=> reg_rdata_q == {5'h0, $past(rt_q)}) // [R21]
      else $error("realtime status read mismatch");
   w1c_clear_a: assert property (reg_wr && reg_addr == `FCM_A_RX_LATCHED && reg_wdata[0] && !det_set[0]
                                 |=> !latched_q[0]) // [R23]
      else $error("latched bit not cleared by write of one");
   set_wins_a: assert property (det_set[0] |=> latched_q[0] && rt_q[0]) // [R23]
      else $error("detect set event lost");
   lpbk_sub_a: assert property (lpbk_slot_s |=> tx_out_q.data == $past(rx_hold_q[tx_in.chan])) // [R6]
      else $error("looped channel does not carry receive data");
   tx_idle_a: assert property (tx_pay && tx_idle_en_q[tx_in.chan] && !loop_send && !recalc
                               |=> tx_out_q.data == $past(tx_idle_q[tx_in.chan])) // [R4]
      else $error("transmit idle code not substituted");
   rx_idle_a: assert property (rx_pay && rx_idle_en_q[rx_in.chan]
                               |=> rx_out_q.data == $past(rx_idle_q[rx_in.chan])) // [R5]
      else $error("receive idle code not substituted");
   mon_capture_a: assert property (tx_out_q.valid && !tx_out_q.fslot && tx_out_q.chan == tx_sel_q[`FCM_F_CHAN]
                                   |=> tx_mon_q == $past(tx_out_q.data)) // [R2]
      else $error("transmit monitor not refreshed");
   det_restart_a: assert property (det_restart[0] |=> tmr_q[0] == '0 && bits_q[0] == '0) // [R19]
      else $error("integration not restarted");
   fbit_keep_a: assert property (loop_send && tx_in.valid && tx_in.fslot && !f_ins_off
                                 |=> tx_out_q.data == $past(tx_in.data)) // [R14]
      else $error("framing bit overwritten by loop code");
   rt_update_a: assert property (det_end[1] && !det_restart[1] |=> rt_q[1] == $past(det_ok[1])) // [R20]
      else $error("realtime detect not updated at period end");
endmodule
`default_nettype wire

// file: test/fcm_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module fcm_far_end
(
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               code_on,
   output var  fcm_pkg::fcm_slot_t tx_in,
   output var  fcm_pkg::fcm_slot_t rx_in
);
   import fcm_pkg::*;
   logic [4:0] ch_q;
   logic [3:0] fr_q;
   logic       mf_start;
   // multiframe start marked once per 16 frames
   assign mf_start = ch_q == 5'h00 && fr_q == 4'h0;
   // one slot counter feeds both streams, so they stay aligned
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ch_q  <= 5'h00;
         fr_q  <= 4'h0;
         tx_in <= '0;
         rx_in <= '0;
      end else begin
         ch_q  <= ch_q + 5'h01;
         if (ch_q == 5'h1f) fr_q <= fr_q + 4'h1;
         tx_in <= '{1'b1, 1'b0, mf_start, ch_q, {3'h0, ch_q}};
         // steady code byte on the line while code_on is high
         rx_in <= '{1'b1, 1'b0, mf_start, ch_q, code_on ? 8'h84 : {3'h5, ch_q}};
      end
   end
endmodule
`default_nettype wire

// file: test/framer_channel_maintenance_bench.sv
`timescale 1ns/1ps
`default_nettype none
module framer_channel_maintenance_bench;
   import fcm_pkg::*;
   logic       ref_clk, rst_n, reg_wr, reg_rd, loop_event_q, code_on;
   logic [8:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_q;
   fcm_slot_t  tx_in, rx_in, tx_out_q, rx_out_q;
   int         err_count, compares;
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   fcm_far_end far (.ref_clk, .rst_n, .code_on, .tx_in, .rx_in);
   fcm_top #(.INTEG_CYCLES(64)) dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q, .tx_in, .rx_in, .tx_out_q, .rx_out_q, .loop_event_q);
   task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(logic [8:0] a, logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [8:0] a, logic [7:0] e, string w);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(w, reg_rdata_q, e);
   endtask
   // bounded wait for a channel at the tx output, then check both outputs
   task automatic slot(logic [4:0] c, logic [7:0] et, logic [7:0] er);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
      end while (tx_out_q.chan !== c && n < 64);
      if (n >= 64) begin
         err_count++;
         tally_and_finish();
      end
      chk("tx slot", tx_out_q.data, et);
      chk("rx slot", rx_out_q.data, er);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      code_on = 1'b0;
      reg_addr = 9'h000;
      reg_wdata = 8'h00;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      wr(9'h189, 8'h06);
      wr(9'h012, 8'h0f);
      rd(9'h189, 8'h06, "tx select");
      rd(9'h1ff, 8'h00, "unmapped");
      rd(9'h0b2, 8'h00, "realtime");
      $display("test registers done");
      wr(9'h1e4, 8'h20);
      wr(9'h1c6, 8'h7e);
      wr(9'h1e0, 8'h40);
      wr(9'h0cf, 8'h55);
      wr(9'h0e1, 8'h80);
      slot(5'h04, 8'h04, 8'ha4);
      slot(5'h05, 8'ha5, 8'ha5);
      slot(5'h06, 8'h7e, 8'ha6);
      slot(5'h0f, 8'h0f, 8'h55);
      rd(9'h1bb, 8'h7e, "tx monitor");
      rd(9'h060, 8'haf, "rx monitor");
      $display("test streams done");
      wr(9'h181, 8'h02);
      wr(9'h1ac, 8'h80);
      wr(9'h183, 8'h01);
      @(posedge ref_clk) #1 chk("loop byte 0", tx_out_q.data, 8'h84);
      @(posedge ref_clk) #1 chk("loop byte 1", tx_out_q.data, 8'h21);
      @(posedge ref_clk) code_on <= 1'b1;
      wr(9'h082, 8'h07);
      wr(9'h0a2, 8'h01);
      wr(9'h0ac, 8'h84);
      wr(9'h0ad, 8'h84);
      repeat (70) @(posedge ref_clk);
      rd(9'h0b2, 8'h01, "realtime up");
      rd(9'h092, 8'h01, "latched set");
      chk("event on", {7'h0, loop_event_q}, 8'h01);
      repeat (3) begin
         repeat (30) @(posedge ref_clk);
         rd(9'h0b2, 8'h01, "poll");
      end
      wr(9'h092, 8'h01);
      rd(9'h092, 8'h00, "latched cleared");
      chk("event off", {7'h0, loop_event_q}, 8'h00);
      @(posedge ref_clk) code_on <= 1'b0;
      repeat (140) @(posedge ref_clk);
      rd(9'h0b2, 8'h00, "realtime down");
      rd(9'h092, 8'h08, "latched clear event");
      $display("test loop codes done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
